// ### common/gauge_cfg.svh
`ifndef GAUGE_CFG_SVH
`define GAUGE_CFG_SVH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_FREQ_HZ 25000000
`define STEP_HOLD_TIME_MS 2000
`define DEGAS_TIME_S 120
`define BLINK_HALF_TIME_MS 250
// Step must stand longer than the hold time, so one cycle is added
`define STEP_HOLD_CYCLES \
    ((64'd`STEP_HOLD_TIME_MS * 64'd`CLK_FREQ_HZ) / 64'd1000 + 64'd1)
`define DEGAS_CYCLES (64'd`DEGAS_TIME_S * 64'd`CLK_FREQ_HZ)
`define BLINK_HALF_CYCLES \
    ((64'd`BLINK_HALF_TIME_MS * 64'd`CLK_FREQ_HZ) / 64'd1000)

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL_OFS 5'h00
`define REG_CONFIG_OFS 5'h04
`define REG_STATUS_OFS 5'h08
`define REG_IRQ_STATUS_OFS 5'h0c
`define REG_IRQ_CLEAR_OFS 5'h10
`define REG_IRQ_ENABLE_OFS 5'h14

// ----------------------------------------------------------------
// Serial control word fields
// ----------------------------------------------------------------
`define CTRL_PIRANI_BIT 0
`define CTRL_DEGAS_BIT 1
`define CTRL_FIL_LSB 2
`define CTRL_FIL_STB_BIT 4
`define CTRL_RESET 5'h00

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define CFG_FIL_LSB 0
`define CFG_SP_INVERT_BIT 2
`define CFG_SP_ENABLE_BIT 3
`define CFG_RESET 4'h0

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define IRQ_ION_ENTER 0
`define IRQ_DEGAS_END 1
`define IRQ_FIL_SWAP 2
`define IRQ_STEP_REJECT 3
`define IRQ_FIL_LOST 4
`define IRQ_WIDTH 5

`endif

// ### common/gauge_pkg.sv
package gauge_pkg;

    typedef enum logic [3:0] {
        ST_PIRANI_ONLY = 4'h1,
        ST_PIRANI_AUTO = 4'h2,
        ST_ION = 4'h4,
        ST_DEGAS = 4'h8
    } branch_state_t;

    typedef enum logic [1:0] {
        FIL_AUTO = 2'h0,
        FIL_ONE = 2'h1,
        FIL_TWO = 2'h2
    } fil_mode_t;

endpackage

// ### design/gauge_ctrl.sv
// Function
// - Control pin changes count only while the external enable is high.
// - A control step is taken only after standing longer than two seconds.
// - Pirani-only request keeps the Pirani branch and lights red.
// - On release, auto-ranging resumes and green lights on ion switch.
// - Degas in the ion branch blinks green and ends after two minutes.
// - Degas removal or completion returns to ion measurement.
// - Automatic filament mode starts on filament 1, swaps on its fault.
// - A directly chosen filament is never swapped on failure.
// - A serial filament choice applies at the next Pirani-to-ion switch.
// - Filament modes are auto, 1 and 2; the parameter waits for power-up.
// - Serial control bits share meaning with the fieldbus control word.
// - The switching-point output has normal or inverted polarity.
// - Normal polarity asserts below threshold, inverted deasserts.
`timescale 1ns/1ps
`include "gauge_cfg.svh"

module gauge_ctrl #(
    parameter logic [31:0] HOLD_CYCLES = 32'(`STEP_HOLD_CYCLES),
    parameter logic [31:0] DEGAS_CYCLES = 32'(`DEGAS_CYCLES),
    parameter logic [31:0] BLINK_CYCLES = 32'(`BLINK_HALF_CYCLES)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // External control pins
    input wire logic i_ext_enable,
    input wire logic i_ctrl_pirani,
    input wire logic i_ctrl_degas,
    // Measurement side
    input wire logic i_sensor_power,
    input wire logic i_below_switchover,
    input wire logic i_below_threshold,
    input wire logic [1:0] i_fil_fault,
    // Avalon-MM slave
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Indicators and outputs
    output logic o_status_red,
    output logic o_status_green,
    output logic o_mode_green,
    output logic o_ion_active,
    output logic o_degas_active,
    output logic [1:0] o_fil_on,
    output logic o_switch_point,
    output logic o_irq
);

    import gauge_pkg::*;

    if (DEGAS_CYCLES == 32'h0 || BLINK_CYCLES == 32'h0)
    begin : g_bad_cfg
        $error("gauge_ctrl: timing counts must be nonzero");
    end

    // ------------------------------------------------------------
    // Pin qualification
    // ------------------------------------------------------------
    logic en_meta_q;
    logic en_sync_q;
    logic [1:0] pins;
    logic [1:0] pin_level;
    logic [1:0] pin_reject;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            en_meta_q <= 1'b0;
            en_sync_q <= 1'b0;
        end
        else
        begin
            en_meta_q <= i_ext_enable;
            en_sync_q <= en_meta_q;
        end
    end

    assign pins = {i_ctrl_degas, i_ctrl_pirani};

    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        step_qualifier #(
            .HOLD_CYCLES(HOLD_CYCLES)
        ) u_qual (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_pin(pins[g]),
            .i_enable(en_sync_q),
            .o_level(pin_level[g]),
            .o_reject(pin_reject[g])
        );
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic ack_q;
    logic wr_stb;
    logic [4:0] ctrl_q;
    logic [3:0] cfg_q;
    logic [`IRQ_WIDTH-1:0] irq_status_q;
    logic [`IRQ_WIDTH-1:0] irq_enable_q;
    logic [`IRQ_WIDTH-1:0] irq_set;
    logic fil_serial_stb;
    logic [31:0] status_word;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            ack_q <= 1'b0;
        else
            ack_q <= (i_avs_read | i_avs_write) & ~ack_q;
    end

    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_stb = i_avs_write & ack_q;
    assign fil_serial_stb = wr_stb && i_avs_address == `REG_CTRL_OFS
        && i_avs_writedata[`CTRL_FIL_STB_BIT];

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ctrl_q <= `CTRL_RESET;
            cfg_q <= `CFG_RESET;
            irq_enable_q <= '0;
        end
        else if (wr_stb)
        begin
            if (i_avs_address == `REG_CTRL_OFS)
                ctrl_q <= {1'b0, i_avs_writedata[3:0]};
            else if (i_avs_address == `REG_CONFIG_OFS)
                cfg_q <= i_avs_writedata[3:0];
            else if (i_avs_address == `REG_IRQ_ENABLE_OFS)
                irq_enable_q <= i_avs_writedata[`IRQ_WIDTH-1:0];
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            irq_status_q <= '0;
        else if (wr_stb && i_avs_address == `REG_IRQ_CLEAR_OFS)
            irq_status_q <= (irq_status_q
                & ~i_avs_writedata[`IRQ_WIDTH-1:0]) | irq_set;
        else
            irq_status_q <= irq_status_q | irq_set;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_avs_readdata <= 32'h0;
        else if (i_avs_read && !ack_q)
        begin
            if (i_avs_address == `REG_CTRL_OFS)
                o_avs_readdata <= {27'h0, ctrl_q};
            else if (i_avs_address == `REG_CONFIG_OFS)
                o_avs_readdata <= {28'h0, cfg_q};
            else if (i_avs_address == `REG_STATUS_OFS)
                o_avs_readdata <= status_word;
            else if (i_avs_address == `REG_IRQ_STATUS_OFS)
                o_avs_readdata <= {27'h0, irq_status_q};
            else if (i_avs_address == `REG_IRQ_ENABLE_OFS)
                o_avs_readdata <= {27'h0, irq_enable_q};
            else
                o_avs_readdata <= 32'h0;
        end
    end

    assign o_irq = |(irq_status_q & irq_enable_q);

    // ------------------------------------------------------------
    // Effective requests
    // ------------------------------------------------------------
    logic pirani_req;
    logic degas_req;
    logic degas_req_q;
    logic degas_rise;

    assign pirani_req = pin_level[0] | ctrl_q[`CTRL_PIRANI_BIT];
    assign degas_req = pin_level[1] | ctrl_q[`CTRL_DEGAS_BIT];
    assign degas_rise = degas_req & ~degas_req_q;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            degas_req_q <= 1'b0;
        else
            degas_req_q <= degas_req;
    end

    // ------------------------------------------------------------
    // Branch state machine
    // ------------------------------------------------------------
    branch_state_t state_q;
    logic [31:0] degas_cnt_q;
    logic degas_done;
    logic ion_enter;

    assign degas_done = (state_q == ST_DEGAS)
        && (degas_cnt_q + 32'h1 >= DEGAS_CYCLES);
    assign ion_enter = (state_q == ST_PIRANI_AUTO) && !pirani_req
        && i_below_switchover && i_sensor_power;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            state_q <= ST_PIRANI_AUTO;
        else if (pirani_req)
            state_q <= ST_PIRANI_ONLY;
        else
        begin
            case (state_q)
                ST_PIRANI_ONLY:
                    state_q <= ST_PIRANI_AUTO;
                ST_PIRANI_AUTO:
                    if (ion_enter)
                        state_q <= ST_ION;
                ST_ION:
                    if (!i_below_switchover || !i_sensor_power)
                        state_q <= ST_PIRANI_AUTO;
                    else if (degas_rise)
                        state_q <= ST_DEGAS;
                ST_DEGAS:
                    if (!i_below_switchover || !i_sensor_power)
                        state_q <= ST_PIRANI_AUTO;
                    else if (!degas_req || degas_done)
                        state_q <= ST_ION;
                default:
                    state_q <= ST_PIRANI_AUTO;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            degas_cnt_q <= 32'h0;
        else if (state_q == ST_DEGAS)
            degas_cnt_q <= degas_cnt_q + 32'h1;
        else
            degas_cnt_q <= 32'h0;
    end

    // Blink enable divider for the mode indicator
    logic [31:0] blink_cnt_q;
    logic blink_q;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b0;
        end
        else if (state_q != ST_DEGAS)
        begin
            blink_cnt_q <= 32'h0;
            blink_q <= 1'b1;
        end
        else if (blink_cnt_q + 32'h1 >= BLINK_CYCLES)
        begin
            blink_cnt_q <= 32'h0;
            blink_q <= ~blink_q;
        end
        else
            blink_cnt_q <= blink_cnt_q + 32'h1;
    end

    // ------------------------------------------------------------
    // Filament selection
    // ------------------------------------------------------------
    fil_mode_t fil_mode_q;
    fil_mode_t fil_pend_q;
    logic fil_pend_vld_q;
    logic pwr_q;
    logic booted_q;
    logic fil_two_q;
    logic fil_dead_q;
    logic ion_on;
    logic sel_fault;
    logic fil_swap;
    logic fil_lost;
    logic use_two;

    assign ion_on = (state_q == ST_ION) || (state_q == ST_DEGAS);
    assign use_two = fil_two_q || fil_mode_q == FIL_TWO;
    assign sel_fault = use_two ? i_fil_fault[1] : i_fil_fault[0];
    assign fil_swap = ion_on && fil_mode_q == FIL_AUTO && !fil_two_q
        && i_fil_fault[0] && !fil_dead_q;
    assign fil_lost = ion_on && !fil_dead_q && sel_fault && !fil_swap;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pwr_q <= 1'b0;
            booted_q <= 1'b0;
        end
        else
        begin
            pwr_q <= i_sensor_power;
            booted_q <= 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            fil_pend_q <= FIL_AUTO;
            fil_pend_vld_q <= 1'b0;
        end
        else if (fil_serial_stb)
        begin
            fil_pend_q <= fil_mode_t'(i_avs_writedata[3:2]);
            fil_pend_vld_q <= 1'b1;
        end
        else if (ion_enter)
            fil_pend_vld_q <= 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            fil_mode_q <= FIL_AUTO;
        else if (!booted_q || (i_sensor_power && !pwr_q))
            fil_mode_q <= fil_mode_t'(cfg_q[1:0]);
        else if (ion_enter && fil_pend_vld_q
            && fil_pend_q != fil_mode_t'(2'h3))
            fil_mode_q <= fil_pend_q;
        else if (state_q == ST_PIRANI_ONLY && !pirani_req)
            fil_mode_q <= FIL_AUTO;
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            fil_two_q <= 1'b0;
            fil_dead_q <= 1'b0;
        end
        else if (!ion_on)
        begin
            fil_two_q <= 1'b0;
            fil_dead_q <= 1'b0;
        end
        else if (fil_swap)
            fil_two_q <= 1'b1;
        else if (fil_lost)
            fil_dead_q <= 1'b1;
    end

    // ------------------------------------------------------------
    // Events and outputs
    // ------------------------------------------------------------
    always_comb
    begin
        irq_set = '0;
        irq_set[`IRQ_ION_ENTER] = ion_enter;
        irq_set[`IRQ_DEGAS_END] = degas_done;
        irq_set[`IRQ_FIL_SWAP] = fil_swap;
        irq_set[`IRQ_STEP_REJECT] = |pin_reject;
        irq_set[`IRQ_FIL_LOST] = fil_lost;
    end

    assign status_word = {21'h0, fil_dead_q, use_two, fil_mode_q,
        pin_level, en_sync_q, state_q};

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_status_red <= 1'b0;
            o_status_green <= 1'b0;
            o_mode_green <= 1'b0;
            o_ion_active <= 1'b0;
            o_degas_active <= 1'b0;
            o_fil_on <= 2'h0;
            o_switch_point <= 1'b0;
        end
        else
        begin
            o_status_red <= (state_q == ST_PIRANI_ONLY);
            o_status_green <= ion_on;
            o_mode_green <= (state_q == ST_DEGAS) & blink_q;
            o_ion_active <= ion_on;
            o_degas_active <= (state_q == ST_DEGAS);
            o_fil_on <= (ion_on && !fil_dead_q)
                ? (use_two ? 2'h2 : 2'h1) : 2'h0;
            o_switch_point <= cfg_q[`CFG_SP_ENABLE_BIT]
                & (i_below_threshold
                ^ cfg_q[`CFG_SP_INVERT_BIT]);
        end
    end

endmodule // gauge_ctrl

// ### design/step_qualifier.sv
`timescale 1ns/1ps
`include "gauge_cfg.svh"

module step_qualifier #(
    parameter logic [31:0] HOLD_CYCLES = 32'(`STEP_HOLD_CYCLES)
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Pin and enable
    input wire logic i_pin,
    input wire logic i_enable,
    // Accepted level and rejected step
    output logic o_level,
    output logic o_reject
);

    logic meta_q;
    logic sync_q;
    logic [31:0] cnt_q;

    if (HOLD_CYCLES == 32'h0)
    begin : g_bad_hold
        $error("step_qualifier: HOLD_CYCLES must be nonzero");
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= i_pin;
            sync_q <= meta_q;
        end
    end

    // ------------------------------------------------------------
    // Hold-time measurement
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_q <= 32'h0;
            o_level <= 1'b0;
            o_reject <= 1'b0;
        end
        else
        begin
            o_reject <= 1'b0;
            if (!i_enable)
            begin
                cnt_q <= 32'h0;
            end
            else if (sync_q != o_level)
            begin
                if (cnt_q + 32'h1 >= HOLD_CYCLES)
                begin
                    o_level <= sync_q;
                    cnt_q <= 32'h0;
                end
                else
                begin
                    cnt_q <= cnt_q + 32'h1;
                end
            end
            else
            begin
                o_reject <= (cnt_q != 32'h0);
                cnt_q <= 32'h0;
            end
        end
    end

endmodule // step_qualifier

// ### verif/ext_ctrl_model.sv
`timescale 1ns/1ps
module ext_ctrl_model (
    // Clock
    input wire logic i_clk,
    // Control pins toward the gauge
    output logic o_enable,
    output logic o_pirani,
    output logic o_degas
);
    initial
    begin
        o_enable = 1'b0;
        o_pirani = 1'b0;
        o_degas = 1'b0;
    end

    // Enable settles a cycle before pins move, then pins hold
    task automatic step(input logic en, input logic pir, input logic deg,
                        input int hold);
        @(posedge i_clk);
        o_enable <= en;
        @(posedge i_clk);
        o_pirani <= pir;
        o_degas <= deg;
        repeat (hold) @(posedge i_clk);
    endtask
endmodule // ext_ctrl_model

// ### verif/gauge_ctrl_properties.sv
`timescale 1ns/1ps
module gauge_ctrl_checker #(
    parameter logic [31:0] HOLD_CYCLES = 32'd8,
    parameter logic [31:0] DEGAS_CYCLES = 32'd40
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ext_enable,
    input wire logic i_ctrl_pirani,
    input wire logic i_sensor_power,
    input wire logic i_below_switchover,
    input wire logic i_below_threshold,
    input wire logic o_status_red,
    input wire logic o_status_green,
    input wire logic o_mode_green,
    input wire logic o_ion_active,
    input wire logic o_degas_active,
    input wire logic [1:0] o_fil_on,
    input wire logic o_switch_point
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // ------------------------------------------------------------
    // Run-length counters
    // ------------------------------------------------------------
    logic [31:0] pir_cnt_q;
    logic [31:0] deg_cnt_q;
    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b)
            pir_cnt_q <= 32'h0;
        else if (i_ctrl_pirani && i_ext_enable)
            pir_cnt_q <= pir_cnt_q + 32'h1;
        else
            pir_cnt_q <= 32'h0;
    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b)
            deg_cnt_q <= 32'h0;
        else if (o_degas_active)
            deg_cnt_q <= deg_cnt_q + 32'h1;
        else
            deg_cnt_q <= 32'h0;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_enable_freeze;
        (!i_ext_enable) [*8] |=> $stable(o_status_red);
    endproperty
    a_enable_freeze: assert property (p_enable_freeze)
        else $error("red changed with enable low");
    property p_pir_hold;
        $rose(o_status_red) |-> pir_cnt_q >= HOLD_CYCLES + 32'h2;
    endproperty
    a_pir_hold: assert property (p_pir_hold)
        else $error("pirani step taken too early");
    property p_red_no_ion;
        o_status_red |-> !o_ion_active && !o_status_green;
    endproperty
    a_red_no_ion: assert property (p_red_no_ion)
        else $error("ion branch while pirani only");
    property p_ion_green;
        o_ion_active |-> o_status_green;
    endproperty
    a_ion_green: assert property (p_ion_green)
        else $error("ion branch without green");
    property p_degas_from_ion;
        $rose(o_degas_active) |-> $past(o_ion_active);
    endproperty
    a_degas_from_ion: assert property (p_degas_from_ion)
        else $error("degas started outside ion branch");
    property p_degas_bound;
        o_degas_active |-> deg_cnt_q <= DEGAS_CYCLES + 32'h1;
    endproperty
    a_degas_bound: assert property (p_degas_bound)
        else $error("degas ran too long");
    property p_blink_degas;
        o_mode_green |-> o_degas_active;
    endproperty
    a_blink_degas: assert property (p_blink_degas)
        else $error("mode green outside degas");
    property p_degas_return;
        $fell(o_degas_active) && !o_status_red && $past(i_below_switchover)
            && $past(i_sensor_power) |-> o_ion_active;
    endproperty
    a_degas_return: assert property (p_degas_return)
        else $error("no ion branch after degas");
    property p_sp_follow;
        $changed(i_below_threshold) && o_switch_point |=> !o_switch_point;
    endproperty
    a_sp_follow: assert property (p_sp_follow)
        else $error("switch point ignored threshold");
    property p_fil_single;
        o_fil_on != 2'b11;
    endproperty
    a_fil_single: assert property (p_fil_single)
        else $error("both filaments lit");
endmodule // gauge_ctrl_checker

bind gauge_ctrl gauge_ctrl_checker #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .DEGAS_CYCLES(DEGAS_CYCLES)
) chk_u (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_ext_enable(i_ext_enable),
    .i_ctrl_pirani(i_ctrl_pirani),
    .i_sensor_power(i_sensor_power),
    .i_below_switchover(i_below_switchover),
    .i_below_threshold(i_below_threshold),
    .o_status_red(o_status_red),
    .o_status_green(o_status_green),
    .o_mode_green(o_mode_green),
    .o_ion_active(o_ion_active),
    .o_degas_active(o_degas_active),
    .o_fil_on(o_fil_on),
    .o_switch_point(o_switch_point)
);

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import gauge_pkg::*;
    localparam int HOLD = 8;
    localparam int DEG = 40;
    localparam int STEP = HOLD + 10;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    wire logic ext_enable, ctrl_pirani, ctrl_degas;
    logic sensor_power = 1'b1;
    logic below_switchover = 1'b0;
    logic below_threshold = 1'b0;
    logic [1:0] fil_fault = 2'h0;
    logic [4:0] avs_address = 5'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, status_red, status_green, mode_green;
    logic ion_active, degas_active, switch_point, irq;
    logic [1:0] fil_on;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;

    always #20 clk = ~clk;

    ext_ctrl_model ctrl_u (.i_clk(clk), .o_enable(ext_enable),
        .o_pirani(ctrl_pirani), .o_degas(ctrl_degas));

    gauge_ctrl #(.HOLD_CYCLES(32'd8), .DEGAS_CYCLES(32'd40),
        .BLINK_CYCLES(32'd3)) dut_u (
        .i_clk(clk), .i_rst_b(rst_b), .i_ext_enable(ext_enable),
        .i_ctrl_pirani(ctrl_pirani), .i_ctrl_degas(ctrl_degas),
        .i_sensor_power(sensor_power), .i_below_switchover(below_switchover),
        .i_below_threshold(below_threshold), .i_fil_fault(fil_fault),
        .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
        .o_status_red(status_red), .o_status_green(status_green),
        .o_mode_green(mode_green), .o_ion_active(ion_active),
        .o_degas_active(degas_active), .o_fil_on(fil_on),
        .o_switch_point(switch_point), .o_irq(irq));

    task automatic give_verdict;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic t_regs;
        bus(0, 5'h04, 32'h0);
        chk(rd, 32'h0);
        bus(1, 5'h08, 32'hffffffff);
        bus(0, 5'h08, 32'h0);
        chk(rd[3:0], ST_PIRANI_AUTO);
        bus(0, 5'h18, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_pirani;
        ctrl_u.step(1'b1, 1'b1, 1'b0, STEP);
        below_switchover <= 1'b1;
        wt(6);
        chk({status_red, status_green, ion_active}, 32'h4);
        bus(1, 5'h14, 32'h1);
        wt(1);
        chk(irq, 32'h0);
        ctrl_u.step(1'b1, 1'b0, 1'b0, STEP);
        wt(4);
        chk({status_red, status_green, ion_active}, 32'h3);
        chk(irq, 32'h1);
        bus(1, 5'h10, 32'h1);
        wt(2);
        chk(irq, 32'h0);
    endtask

    task automatic t_reject;
        ctrl_u.step(1'b1, 1'b1, 1'b0, HOLD - 3);
        ctrl_u.step(1'b1, 1'b0, 1'b0, STEP);
        wt(4);
        chk({status_red, ion_active}, 32'h1);
        bus(0, 5'h0c, 32'h0);
        chk(rd[3], 32'h1);
        ctrl_u.step(1'b0, 1'b1, 1'b0, STEP);
        wt(4);
        chk(status_red, 32'h0);
        ctrl_u.step(1'b0, 1'b0, 1'b0, 2);
        ctrl_u.step(1'b1, 1'b0, 1'b0, 4);
    endtask

    task automatic t_degas;
        int n;
        int hi;
        int lo;
        n = 0;
        hi = 0;
        lo = 0;
        ctrl_u.step(1'b1, 1'b0, 1'b1, HOLD + 4);
        wt(2);
        chk(degas_active, 32'h1);
        while (degas_active === 1'b1 && n < 200)
        begin
            hi += (mode_green === 1'b1);
            lo += (mode_green === 1'b0);
            n++;
            wt(1);
        end
        chk(hi > 0 && lo > 0, 32'h1);
        chk(n >= DEG - 6 && n <= DEG + 1, 32'h1);
        wt(2);
        chk(ion_active, 32'h1);
        bus(0, 5'h0c, 32'h0);
        chk(rd[1], 32'h1);
        ctrl_u.step(1'b1, 1'b0, 1'b0, STEP);
        ctrl_u.step(1'b1, 1'b0, 1'b1, STEP);
        chk(degas_active, 32'h1);
        ctrl_u.step(1'b1, 1'b0, 1'b0, STEP);
        wt(2);
        chk({degas_active, ion_active}, 32'h1);
    endtask

    task automatic t_fil;
        chk(fil_on, 32'h1);
        @(posedge clk);
        fil_fault <= 2'h1;
        wt(4);
        chk(fil_on, 32'h2);
        bus(0, 5'h0c, 32'h0);
        chk(rd[2], 32'h1);
        fil_fault <= 2'h0;
        bus(1, 5'h04, 32'h1);
        wt(4);
        chk(fil_on, 32'h2);
        @(posedge clk);
        sensor_power <= 1'b0;
        wt(3);
        @(posedge clk);
        sensor_power <= 1'b1;
        wt(6);
        chk(fil_on, 32'h1);
        @(posedge clk);
        fil_fault <= 2'h1;
        wt(4);
        chk(fil_on, 32'h0);
        bus(0, 5'h0c, 32'h0);
        chk(rd[4], 32'h1);
        fil_fault <= 2'h0;
        bus(1, 5'h00, 32'h18);
        wt(4);
        chk(fil_on == 2'h2, 32'h0);
        @(posedge clk);
        below_switchover <= 1'b0;
        wt(4);
        @(posedge clk);
        below_switchover <= 1'b1;
        wt(6);
        chk(fil_on, 32'h2);
        bus(1, 5'h00, 32'h2);
        wt(STEP);
        chk(degas_active, 32'h1);
        bus(1, 5'h00, 32'h0);
        wt(STEP);
        chk(degas_active, 32'h0);
    endtask

    task automatic t_sp;
        bus(1, 5'h04, 32'h9);
        below_threshold <= 1'b1;
        wt(3);
        chk(switch_point, 32'h1);
        bus(1, 5'h04, 32'hd);
        wt(3);
        chk(switch_point, 32'h0);
        @(posedge clk);
        below_threshold <= 1'b0;
        wt(3);
        chk(switch_point, 32'h1);
    endtask

    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        t_pirani();
        t_reject();
        t_degas();
        t_fil();
        t_sp();
        give_verdict();
    end
endmodule // tb_top
